// File: verilog/e1s_regs.svh
/*
 Register offsets, field positions, reset values and timing figures
 of the E1 status and error counter block.
 Assumes a 20 MHz system clock and an 8-bit host register port.
*/
`ifndef E1S_REGS_SVH
`define E1S_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define E1S_ADR_VCNT_HI   8'h00
`define E1S_ADR_VCNT_LO   8'h01
`define E1S_ADR_FAS_CRC   8'h02
`define E1S_ADR_CRC_LO    8'h03
`define E1S_ADR_FAS_EB    8'h04
`define E1S_ADR_EB_LO     8'h05
`define E1S_ADR_ALM_STAT  8'h06
`define E1S_ADR_EVT_STAT  8'h07
`define E1S_ADR_ALM_MASK  8'h16
`define E1S_ADR_EVT_MASK  8'h17

// ****************************************
// Event status bit positions
// ****************************************
`define E1S_B_RMF    7
`define E1S_B_RAF    6
`define E1S_B_TMF    5
`define E1S_B_SEC    4
`define E1S_B_TAF    3
`define E1S_B_TX_CLOCK_LOSS_FLAG   2
`define E1S_B_RX_CRC_MULTIFRAME_FLAG   1
`define E1S_B_TX_SLIP_FLAG  0

// ****************************************
// Reset values
// ****************************************
`define E1S_MASK_RST  8'h00
`define E1S_STAT_RST  8'h00

// ****************************************
// Timing
// ****************************************
`define E1S_CLK_NS     50
`define E1S_TX_CLOCK_LOSS_FLAG_NS    3900
`define E1S_MF_US      2000
`define E1S_RX_HZ      2048000
`define E1S_FAST_DIV   16

`endif

// File: verilog/e1s_pkg.sv
/*
 Types of the E1 status and error counter block.
 Assumes the constants header is compiled alongside.
*/
`default_nettype none

package e1s_pkg;

	// Line side inputs, all from the line clock domains
	typedef struct packed {
		logic rx_mf;
		logic rx_align;
		logic tx_mf;
		logic tx_align;
		logic rx_crc_mf;
		logic tx_slip;
		logic rx_clk;
		logic tx_line_clock;
		logic bpv;
		logic hdb3_code;
		logic cv;
		logic crc_err;
		logic ebit_stb;
		logic ebit_val;
		logic fas_err;
		logic rx_sync_loss;
		logic fas_loss;
		logic crc_loss;
		logic cas_search;
	} e1s_line_t;

	// Control bits, synchronous to CLK
	typedef struct packed {
		logic interval_select_bit;
		logic violation_type_bit;
		logic rx_hdb3_enable_bit;
		logic clock_loss_pin_enable;
		logic crc4_enable;
	} e1s_cfg_t;

	typedef struct packed {
		logic [15:0] vc;
		logic [9:0]  crc;
		logic [9:0]  eb;
		logic [11:0] fas;
	} e1s_counts_t;

endpackage : e1s_pkg

`default_nettype wire

// File: verilog/e1s_status_counters.sv
/*
 Frame event flags, interrupt masking and four saturating error
 counters of an E1 framer, read over the 8-bit host port.
 Assumes the host port is synchronous to CLK; line inputs are
 asynchronous levels held for at least three CLK periods.
*/
`include "e1s_regs.svh"
`default_nettype none

// Functional notes
// - Receive multiframe flag sets at every receive multiframe boundary.
// - Receive align flag sets at the start of every align frame.
// - Transmit multiframe flag sets at every transmit multiframe boundary.
// - Transmit align flag sets at the start of every transmit align frame.
// - Interval flag every second of receive clock, or 62.5 ms when selected.
// - Clock-loss flag after 3.9 us without tx clock edges; pin when enabled.
// - CRC multiframe flag on boundaries, or every 2 ms with CRC-4 off.
// - Transmit slip flag on each transmit elastic store slip.
// - Mask at 0x16 gates alarm status bits; one enables.
// - Mask at 0x17 gates event status bits; one enables.
// - All four counts update at each interval boundary and then hold.
// - Every counter saturates, never rolls over.
// - 16-bit violation count, high byte at 0x00, low at 0x01.
// - Type bit zero counts bipolar violations, skipping HDB3 codewords when HDB3 receive is enabled.
// - Type bit one counts code violations.
// - Violation counter runs through sync loss, stops at 65535.
// - 10-bit CRC error count, bits 9:8 at 0x02, 7:0 at 0x03.
// - CRC and E-bit counters stop on FAS or CRC-4 sync loss.
// - E-bit counter increments on each received zero E-bit.
// - E-bit count bits 9:8 at 0x04, 7:0 at 0x05.
// - 12-bit FAS error counter, idle in sync loss or any search.
// - FAS bits 11:6 at 0x02 bits 7:2, bits 5:0 at 0x04 bits 7:2.
// - Status write refreshes only the bits written as one.
// - Interrupt pin low on unmasked event, released once its status bit is written as one.
// - Alarm interrupt on each change of alarm bits 3:0 and each rise of bits 7:4; a status write releases it.
module e1s_status_counters
	import e1s_pkg::*;
#(
	parameter int unsigned RX_TICKS_SEC = `E1S_RX_HZ,
	parameter int unsigned MF_CYCLES    = `E1S_MF_US * 1000 / `E1S_CLK_NS
) (
	input  wire logic        CLK,
	input  wire logic        SYS_RST,
	input  wire logic [7:0]  ADDR,
	input  wire logic [7:0]  WR_DATA,
	input  wire logic        WR_STB,
	input  wire logic        RD_STB,
	output var  logic [7:0]  RD_DATA,
	output var  logic        INT_N,
	output var  logic        TX_CLOCK_LOSS_FLAG_PIN,
	input  wire e1s_cfg_t    CFG,
	input  wire e1s_line_t   LINE_IN,
	input  wire logic [7:0]  ALARM_IN
);

	localparam logic [21:0] IVL_SEC  = 22'(RX_TICKS_SEC - 1);
	localparam logic [21:0] IVL_FAST = 22'(RX_TICKS_SEC / `E1S_FAST_DIV - 1);
	localparam logic [19:0] MF_LAST  = 20'(MF_CYCLES - 1);
	localparam int          TX_CLOCK_LOSS_FLAG_CYC = (`E1S_TX_CLOCK_LOSS_FLAG_NS + `E1S_CLK_NS - 1) / `E1S_CLK_NS;
	localparam logic [7:0]  TX_CLOCK_LOSS_FLAG_LIM = 8'(TX_CLOCK_LOSS_FLAG_CYC);

	function automatic logic [15:0] e1s_sat_inc(input logic [15:0] v, input logic [15:0] mx,
		input logic inc);
		return (inc && v != mx) ? 16'(v + 16'h0001) : v;
	endfunction : e1s_sat_inc

	// ****************************************
	// Synchronisers
	// ****************************************
	e1s_line_t  ln_s1_reg, ln_s2_reg, ln_s3_reg;
	logic [7:0] al_s1_reg, al_s2_reg, al_s3_reg;
	e1s_line_t  ln_rise;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ln_s1_reg <= '0;
			ln_s2_reg <= '0;
			ln_s3_reg <= '0;
			al_s1_reg <= 8'h00;
			al_s2_reg <= 8'h00;
			al_s3_reg <= 8'h00;
		end else begin
			ln_s1_reg <= LINE_IN;
			ln_s2_reg <= ln_s1_reg;
			ln_s3_reg <= ln_s2_reg;
			al_s1_reg <= ALARM_IN;
			al_s2_reg <= al_s1_reg;
			al_s3_reg <= al_s2_reg;
		end
	end

	assign ln_rise = ln_s2_reg & ~ln_s3_reg;

	// ****************************************
	// Timers
	// ****************************************
	logic [21:0] ivl_cnt_reg, ivl_cnt_next;
	logic [19:0] mf_cnt_reg, mf_cnt_next;
	logic [7:0]  idle_reg, idle_next;
	logic        loss_reg, loss_next;
	logic        tick;
	logic        mf_auto;

	always_comb begin
		ivl_cnt_next = ivl_cnt_reg;
		tick = 1'b0;
		if (ln_rise.rx_clk) begin
			if (ivl_cnt_reg >= (CFG.interval_select_bit ? IVL_FAST : IVL_SEC)) begin
				ivl_cnt_next = 22'h000000;
				tick = 1'b1;
			end else begin
				ivl_cnt_next = 22'(ivl_cnt_reg + 22'h000001);
			end
		end
		mf_auto = (mf_cnt_reg == MF_LAST);
		mf_cnt_next = mf_auto ? 20'h00000 : 20'(mf_cnt_reg + 20'h00001);
		// Any edge of the synchronised tx clock restarts the idle count
		if (ln_s2_reg.tx_line_clock != ln_s3_reg.tx_line_clock) begin
			idle_next = 8'h00;
		end else if (idle_reg != TX_CLOCK_LOSS_FLAG_LIM) begin
			idle_next = 8'(idle_reg + 8'h01);
		end else begin
			idle_next = idle_reg;
		end
		loss_next = (idle_next == TX_CLOCK_LOSS_FLAG_LIM);
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ivl_cnt_reg <= 22'h000000;
			mf_cnt_reg  <= 20'h00000;
			idle_reg    <= 8'h00;
			loss_reg    <= 1'b0;
		end else begin
			ivl_cnt_reg <= ivl_cnt_next;
			mf_cnt_reg  <= mf_cnt_next;
			idle_reg    <= idle_next;
			loss_reg    <= loss_next;
		end
	end

	// ****************************************
	// Status flags and interrupt
	// ****************************************
	logic [7:0] evt_set, alm_set;
	logic [7:0] evt_st_reg, evt_st_next, alm_st_reg, alm_st_next;
	logic [7:0] evt_rd_reg, evt_rd_next, alm_rd_reg, alm_rd_next;
	logic [7:0] evt_mask_reg, evt_mask_next, alm_mask_reg, alm_mask_next;
	logic [7:0] evt_clr, alm_clr;
	logic       int_n_next, tx_clock_loss_flag_next;

	always_comb begin
		evt_set = 8'h00;
		evt_set[`E1S_B_RMF]   = ln_rise.rx_mf;
		evt_set[`E1S_B_RAF]   = ln_rise.rx_align;
		evt_set[`E1S_B_TMF]   = ln_rise.tx_mf;
		evt_set[`E1S_B_SEC]   = tick;
		evt_set[`E1S_B_TAF]   = ln_rise.tx_align;
		evt_set[`E1S_B_TX_CLOCK_LOSS_FLAG]  = loss_next & ~loss_reg;
		evt_set[`E1S_B_RX_CRC_MULTIFRAME_FLAG]  = CFG.crc4_enable ? ln_rise.rx_crc_mf : mf_auto;
		evt_set[`E1S_B_TX_SLIP_FLAG] = ln_rise.tx_slip;
		// Upper half are events, lower half alarms that flag both edges
		alm_set = {al_s2_reg[7:4] & ~al_s3_reg[7:4], al_s2_reg[3:0] ^ al_s3_reg[3:0]};
		evt_clr = (WR_STB && ADDR == `E1S_ADR_EVT_STAT) ? WR_DATA : 8'h00;
		alm_clr = (WR_STB && ADDR == `E1S_ADR_ALM_STAT) ? WR_DATA : 8'h00;
		// Set wins over a clear in the same cycle
		evt_st_next = (evt_st_reg & ~evt_clr) | evt_set;
		alm_st_next = (alm_st_reg & ~alm_clr) | alm_set;
		evt_rd_next = (evt_rd_reg & ~evt_clr) | (evt_st_reg & evt_clr);
		alm_rd_next = (alm_rd_reg & ~alm_clr) | (alm_st_reg & alm_clr);
		alm_mask_next = (WR_STB && ADDR == `E1S_ADR_ALM_MASK) ? WR_DATA : alm_mask_reg;
		evt_mask_next = (WR_STB && ADDR == `E1S_ADR_EVT_MASK) ? WR_DATA : evt_mask_reg;
		int_n_next = ~|((alm_st_reg & alm_mask_reg) | (evt_st_reg & evt_mask_reg));
		tx_clock_loss_flag_next = loss_reg & CFG.clock_loss_pin_enable;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			evt_st_reg   <= `E1S_STAT_RST;
			alm_st_reg   <= `E1S_STAT_RST;
			evt_rd_reg   <= `E1S_STAT_RST;
			alm_rd_reg   <= `E1S_STAT_RST;
			evt_mask_reg <= `E1S_MASK_RST;
			alm_mask_reg <= `E1S_MASK_RST;
			INT_N        <= 1'b1;
			TX_CLOCK_LOSS_FLAG_PIN     <= 1'b0;
		end else begin
			evt_st_reg   <= evt_st_next;
			alm_st_reg   <= alm_st_next;
			evt_rd_reg   <= evt_rd_next;
			alm_rd_reg   <= alm_rd_next;
			evt_mask_reg <= evt_mask_next;
			alm_mask_reg <= alm_mask_next;
			INT_N        <= int_n_next;
			TX_CLOCK_LOSS_FLAG_PIN     <= tx_clock_loss_flag_next;
		end
	end

	// ****************************************
	// Error counters
	// ****************************************
	e1s_counts_t acc_reg, acc_next, cnt_reg, cnt_next;
	logic        inc_vc, inc_crc, inc_eb, inc_fas;

	always_comb begin
		// Bipolar mode with HDB3 receive enabled skips violations that belong to a valid HDB3 codeword
		inc_vc = CFG.violation_type_bit ? ln_rise.cv :
			ln_rise.bpv & ~(CFG.rx_hdb3_enable_bit & ln_s2_reg.hdb3_code);
		inc_crc = ln_rise.crc_err & ~ln_s2_reg.fas_loss & ~ln_s2_reg.crc_loss;
		inc_eb = ln_rise.ebit_stb & ~ln_s2_reg.ebit_val
			& ~ln_s2_reg.fas_loss & ~ln_s2_reg.crc_loss;
		inc_fas = ln_rise.fas_err & ~ln_s2_reg.rx_sync_loss & ~ln_s2_reg.fas_loss
			& ~ln_s2_reg.cas_search & ~ln_s2_reg.crc_loss;
		acc_next = tick ? '0 : acc_reg;
		acc_next.vc  = e1s_sat_inc(acc_next.vc, 16'hffff, inc_vc);
		acc_next.crc = 10'(e1s_sat_inc({6'h00, acc_next.crc}, 16'h03ff, inc_crc));
		acc_next.eb  = 10'(e1s_sat_inc({6'h00, acc_next.eb}, 16'h03ff, inc_eb));
		acc_next.fas = 12'(e1s_sat_inc({4'h0, acc_next.fas}, 16'h0fff, inc_fas));
		cnt_next = tick ? acc_reg : cnt_reg;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			acc_reg <= '0;
			cnt_reg <= '0;
		end else begin
			acc_reg <= acc_next;
			cnt_reg <= cnt_next;
		end
	end

	// ****************************************
	// Host read port
	// ****************************************
	logic [7:0] rd_next;

	always_comb begin
		unique case (ADDR)
			`E1S_ADR_VCNT_HI:  rd_next = cnt_reg.vc[15:8];
			`E1S_ADR_VCNT_LO:  rd_next = cnt_reg.vc[7:0];
			`E1S_ADR_FAS_CRC:  rd_next = {cnt_reg.fas[11:6], cnt_reg.crc[9:8]};
			`E1S_ADR_CRC_LO:   rd_next = cnt_reg.crc[7:0];
			`E1S_ADR_FAS_EB:   rd_next = {cnt_reg.fas[5:0], cnt_reg.eb[9:8]};
			`E1S_ADR_EB_LO:    rd_next = cnt_reg.eb[7:0];
			`E1S_ADR_ALM_STAT: rd_next = alm_rd_reg;
			`E1S_ADR_EVT_STAT: rd_next = evt_rd_reg;
			`E1S_ADR_ALM_MASK: rd_next = alm_mask_reg;
			`E1S_ADR_EVT_MASK: rd_next = evt_mask_reg;
			default:           rd_next = 8'h00;
		endcase
		if (!RD_STB) begin
			rd_next = RD_DATA;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			RD_DATA <= 8'h00;
		end else begin
			RD_DATA <= rd_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_unmasked_evt;
		|(evt_st_reg & evt_mask_reg);
	endsequence

	sequence s_int_low;
		##1 !INT_N;
	endsequence

	a_rmf_flag_set: assert property (ln_rise.rx_mf |=> evt_st_reg[`E1S_B_RMF])
		else $error("receive multiframe flag not set");
	a_raf_flag_set: assert property (ln_rise.rx_align |=> evt_st_reg[`E1S_B_RAF])
		else $error("receive align flag not set");
	a_tmf_flag_set: assert property (ln_rise.tx_mf |=> evt_st_reg[`E1S_B_TMF])
		else $error("transmit multiframe flag not set");
	a_taf_flag_set: assert property (ln_rise.tx_align |=> evt_st_reg[`E1S_B_TAF])
		else $error("transmit align flag not set");
	a_sec_tick_flag: assert property (tick |=> evt_st_reg[`E1S_B_SEC] && ivl_cnt_reg == 22'h000000)
		else $error("interval flag or timer restart missing");
	a_tx_clock_loss_flag_pin_out: assert property (loss_reg && CFG.clock_loss_pin_enable |=> TX_CLOCK_LOSS_FLAG_PIN)
		else $error("clock loss pin not driven");
	a_rx_crc_multiframe_flag_auto_set: assert property (!CFG.crc4_enable && mf_auto |=> evt_st_reg[`E1S_B_RX_CRC_MULTIFRAME_FLAG])
		else $error("free running crc multiframe flag missing");
	a_tx_slip_flag_flag_set: assert property (ln_rise.tx_slip |=> evt_st_reg[`E1S_B_TX_SLIP_FLAG])
		else $error("transmit slip flag not set");
	a_count_latch: assert property (tick |=> cnt_reg == $past(acc_reg))
		else $error("counts not transferred at interval");
	a_vc_saturate: assert property (acc_reg.vc == 16'hffff && !tick |=> acc_reg.vc == 16'hffff)
		else $error("violation counter rolled over");
	a_int_assert: assert property (s_unmasked_evt |-> s_int_low)
		else $error("interrupt not asserted");
	a_status_keep: assert property (WR_STB && ADDR == `E1S_ADR_EVT_STAT |=>
		(evt_rd_reg & ~$past(WR_DATA)) == ($past(evt_rd_reg) & ~$past(WR_DATA)))
		else $error("unselected status bit changed");

	sequence s_crc_eb_gate;
		(ln_s2_reg.fas_loss || ln_s2_reg.crc_loss) && !tick;
	endsequence

	sequence s_fas_gate;
		(ln_s2_reg.rx_sync_loss || ln_s2_reg.fas_loss || ln_s2_reg.cas_search || ln_s2_reg.crc_loss) && !tick;
	endsequence

	sequence s_none_pending;
		((alm_st_reg & alm_mask_reg) | (evt_st_reg & evt_mask_reg)) == 8'h00;
	endsequence

	a_rx_crc_multiframe_flag_crc_set: assert property (CFG.crc4_enable && ln_rise.rx_crc_mf |=> evt_st_reg[`E1S_B_RX_CRC_MULTIFRAME_FLAG])
		else $error("crc multiframe flag not set");
	a_mf_restart: assert property (mf_auto |=> mf_cnt_reg == 20'h00000)
		else $error("multiframe timer did not restart");
	a_tx_clock_loss_flag_flag_set: assert property (loss_next && !loss_reg |=> evt_st_reg[`E1S_B_TX_CLOCK_LOSS_FLAG])
		else $error("clock loss flag not set");
	a_tx_clock_loss_flag_idle_time: assert property (idle_reg == 8'(TX_CLOCK_LOSS_FLAG_LIM - 8'h01)
		&& ln_s2_reg.tx_line_clock == ln_s3_reg.tx_line_clock |=> loss_reg)
		else $error("clock loss not declared after idle time");
	a_set_wins: assert property (|evt_set |=> (evt_st_reg & $past(evt_set)) == $past(evt_set))
		else $error("event flag lost against a clear");
	a_evt_clear: assert property (WR_STB && ADDR == `E1S_ADR_EVT_STAT && evt_set == 8'h00
		|=> (evt_st_reg & $past(WR_DATA)) == 8'h00)
		else $error("event flag not cleared");
	a_int_release: assert property (s_none_pending |=> INT_N)
		else $error("interrupt held without a pending source");
	a_alm_mask_int: assert property (|(alm_st_reg & alm_mask_reg) |=> !INT_N)
		else $error("unmasked alarm without interrupt");
	a_alm_change: assert property (al_s2_reg[3:0] != al_s3_reg[3:0] |=>
		(alm_st_reg[3:0] & $past(al_s2_reg[3:0] ^ al_s3_reg[3:0])) == $past(al_s2_reg[3:0] ^ al_s3_reg[3:0]))
		else $error("alarm change not flagged");
	a_alm_clear: assert property (WR_STB && ADDR == `E1S_ADR_ALM_STAT && alm_set == 8'h00
		|=> (alm_st_reg & $past(WR_DATA)) == 8'h00)
		else $error("alarm flag not released");
	a_alm_mask_wr: assert property (WR_STB && ADDR == `E1S_ADR_ALM_MASK
		|=> alm_mask_reg == $past(WR_DATA))
		else $error("alarm mask not written");
	a_evt_mask_wr: assert property (WR_STB && ADDR == `E1S_ADR_EVT_MASK
		|=> evt_mask_reg == $past(WR_DATA))
		else $error("event mask not written");
	a_status_latch: assert property (WR_STB && ADDR == `E1S_ADR_EVT_STAT
		|=> (evt_rd_reg & $past(WR_DATA)) == ($past(evt_st_reg) & $past(WR_DATA)))
		else $error("status latch not refreshed");
	a_count_restart: assert property (tick |=> acc_reg.vc == 16'($past(inc_vc))
		&& acc_reg.crc == 10'($past(inc_crc)) && acc_reg.fas == 12'($past(inc_fas)))
		else $error("accumulators not restarted at interval");
	a_vc_step: assert property (inc_vc && !tick && acc_reg.vc != 16'hffff
		|=> acc_reg.vc == 16'($past(acc_reg.vc) + 16'h0001))
		else $error("violation not counted");
	a_hdb3_skip: assert property (!CFG.violation_type_bit && CFG.rx_hdb3_enable_bit
		&& ln_s2_reg.hdb3_code && !tick |=> acc_reg.vc == $past(acc_reg.vc))
		else $error("hdb3 codeword counted as violation");
	a_cv_only: assert property (CFG.violation_type_bit && !ln_rise.cv && !tick
		|=> acc_reg.vc == $past(acc_reg.vc))
		else $error("non code violation counted");
	a_crc_gate: assert property (s_crc_eb_gate |=> acc_reg.crc == $past(acc_reg.crc))
		else $error("crc count moved during sync loss");
	a_eb_gate: assert property (s_crc_eb_gate |=> acc_reg.eb == $past(acc_reg.eb))
		else $error("far end count moved during sync loss");
	a_fas_gate: assert property (s_fas_gate |=> acc_reg.fas == $past(acc_reg.fas))
		else $error("alignment count moved during search");
	a_ebit_step: assert property (ln_rise.ebit_stb && !ln_s2_reg.ebit_val && !ln_s2_reg.fas_loss
		&& !ln_s2_reg.crc_loss && !tick && acc_reg.eb != 10'h3ff |=> acc_reg.eb == 10'($past(acc_reg.eb) + 10'h001))
		else $error("zero far end bit not counted");
	a_crc_saturate: assert property (acc_reg.crc == 10'h3ff && !tick
		|=> acc_reg.crc == 10'h3ff)
		else $error("crc counter rolled over");
	a_eb_saturate: assert property (acc_reg.eb == 10'h3ff && !tick
		|=> acc_reg.eb == 10'h3ff)
		else $error("far end counter rolled over");
	a_fas_saturate: assert property (acc_reg.fas == 12'hfff && !tick
		|=> acc_reg.fas == 12'hfff)
		else $error("alignment counter rolled over");
	a_vc_high_rd: assert property (RD_STB && ADDR == `E1S_ADR_VCNT_HI
		|=> RD_DATA == $past(cnt_reg.vc[15:8]))
		else $error("violation high byte misread");
	a_crc_low_rd: assert property (RD_STB && ADDR == `E1S_ADR_CRC_LO
		|=> RD_DATA == $past(cnt_reg.crc[7:0]))
		else $error("crc low byte misread");
	a_fas_high_rd: assert property (RD_STB && ADDR == `E1S_ADR_FAS_CRC
		|=> RD_DATA == {$past(cnt_reg.fas[11:6]), $past(cnt_reg.crc[9:8])})
		else $error("alignment high bits misread");
	a_eb_high_rd: assert property (RD_STB && ADDR == `E1S_ADR_FAS_EB
		|=> RD_DATA == {$past(cnt_reg.fas[5:0]), $past(cnt_reg.eb[9:8])})
		else $error("far end high bits misread");

endmodule : e1s_status_counters

`default_nettype wire

// File: test/e1s_line_model.sv
/*
 Line side model: free-running receive line clock, gated transmit line
 clock, held levels and event pulses on request of the bench.
 Assumes pulse is called just after a falling edge of clk.
*/
`default_nettype none

module e1s_line_model
	import e1s_pkg::*;
(
	input  wire logic      clk,
	output var  e1s_line_t line_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************
	// Line clocks, levels and pulses
	// ************************************
	e1s_line_t  lvl;
	e1s_line_t  pls;
	logic [1:0] ph;
	logic       rx_ck;
	logic       tx_ck;
	logic       tx_run;

	initial begin
		lvl = '0;
		pls = '0;
		ph = 2'h0;
		rx_ck = 1'b0;
		tx_ck = 1'b0;
		tx_run = 1'b1;
	end

	// Four clk per half period keeps each level past the input syncs
	always @(negedge clk) begin
		ph <= ph + 2'h1;
		if (ph == 2'h3) begin
			rx_ck <= ~rx_ck;
			tx_ck <= tx_run ? ~tx_ck : tx_ck;
		end
	end

	always_comb begin
		line_out = e1s_line_t'(lvl | pls);
		line_out.rx_clk = rx_ck;
		line_out.tx_line_clock = tx_ck;
	end

	task automatic pulse(input e1s_line_t q, input int n);
		repeat (n) begin
			pls = q;
			repeat (4) @(negedge clk);
			pls = '0;
			repeat (4) @(negedge clk);
		end
	endtask : pulse

endmodule : e1s_line_model

`default_nettype wire

// File: test/tb.sv
/*
 Self-checking bench of the E1 status and error counter block.
 Assumes the package, the design and the line model are compiled first.
*/
`default_nettype none
`define CHK(n,e,s) begin n_checks++; if ((s) !== (e)) begin err_count++; $display("mismatch %s exp %h got %h",n,e,s); end end

module tb
	import e1s_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************
	// Signals and instances
	// ************************************
	logic       clk;
	logic       sys_rst;
	logic [7:0] addr;
	logic [7:0] wr_data;
	logic       wr_stb;
	logic       rd_stb;
	logic [7:0] rd_data;
	logic       int_n;
	logic       tx_clock_loss_flag_pin;
	e1s_cfg_t   cfg;
	e1s_line_t  line_in;
	logic [7:0] alarm;
	int         err_count;
	int         n_checks;
	int         k;
	logic [7:0] d;
	logic [7:0] prv;
	logic [7:0] m;
	e1s_line_t  p;
	int         ev_i[6] = '{18, 17, 16, 15, 14, 13};
	int         st_i[6] = '{7, 6, 5, 3, 1, 0};
	logic [7:0] ra[9] = '{8'h16, 8'h17, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h20};

	// Short interval and multiframe counts keep the run brief
	e1s_status_counters #(
		.RX_TICKS_SEC(2048),
		.MF_CYCLES   (40)
	) u_e1s_status_counters (
		.CLK     (clk),
		.SYS_RST (sys_rst),
		.ADDR    (addr),
		.WR_DATA (wr_data),
		.WR_STB  (wr_stb),
		.RD_STB  (rd_stb),
		.RD_DATA (rd_data),
		.INT_N   (int_n),
		.TX_CLOCK_LOSS_FLAG_PIN(tx_clock_loss_flag_pin),
		.CFG     (cfg),
		.LINE_IN (line_in),
		.ALARM_IN(alarm)
	);

	e1s_line_model u_e1s_line_model (
		.clk     (clk),
		.line_out(line_in)
	);

	always #25 clk = ~clk;

	// ************************************
	// Host port tasks
	// ************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		addr = a;
		wr_data = v;
		wr_stb = 1'b1;
		@(negedge clk);
		wr_stb = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		@(negedge clk);
		addr = a;
		rd_stb = 1'b1;
		@(negedge clk);
		rd_stb = 1'b0;
		@(negedge clk);
		q = rd_data;
	endtask : rd

	task automatic stat(input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
		wr(a, v);
		rd(a, q);
	endtask : stat

	task automatic wait_int(input int lim, output int j);
		j = 0;
		while (int_n !== 1'b0 && j < lim) begin
			@(negedge clk);
			j++;
		end
	endtask : wait_int

	task automatic wait_sec(output int j);
		logic [7:0] q;
		wr(8'h17, 8'h10);
		stat(8'h07, 8'h10, q);
		wait_int(20000, j);
		`CHK("sec_int", 1'b0, int_n)
		stat(8'h07, 8'h10, q);
		`CHK("sec_flag", 8'h10, q & 8'h10)
	endtask : wait_sec

	task automatic row(input e1s_cfg_t c, input e1s_line_t l, input e1s_line_t q, input int n, input e1s_counts_t e);
		logic [7:0] b[6];
		int         j;
		cfg = c;
		u_e1s_line_model.lvl = l;
		wait_sec(j);
		u_e1s_line_model.pulse(q, n);
		wait_sec(j);
		for (int a = 0; a < 6; a++) rd(8'(a), b[a]);
		`CHK("vc", e.vc, {b[0], b[1]})
		`CHK("crc", e.crc, {b[2][1:0], b[3]})
		`CHK("eb", e.eb, {b[4][1:0], b[5]})
		`CHK("fas", e.fas, {b[2][7:2], b[4][7:2]})
	endtask : row

	task automatic results();
		if (err_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results

	initial begin
		repeat (70000) @(posedge clk);
		err_count++;
		results();
	end

	// ************************************
	// Test sequence
	// ************************************
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		addr = 8'h00;
		wr_data = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		alarm = 8'h00;
		err_count = 0;
		n_checks = 0;
		cfg = e1s_cfg_t'(5'h13);
		repeat (5) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk);
		// Counters are read-only and an unmapped offset reads zero
		wr(8'h00, 8'hff);
		for (int i = 0; i < 9; i++) begin
			rd(ra[i], d);
			`CHK("reset", 8'h00, d)
		end
		wr(8'h16, 8'ha5);
		wr(8'h17, 8'h5a);
		rd(8'h16, d);
		`CHK("mask1", 8'ha5, d)
		rd(8'h17, d);
		`CHK("mask2", 8'h5a, d)
		wr(8'h16, 8'h00);
		for (int i = 0; i < 6; i++) begin
			m = 8'h01 << st_i[i];
			p = '0;
			p[ev_i[i]] = 1'b1;
			wr(8'h17, m);
			stat(8'h07, m, prv);
			u_e1s_line_model.pulse(p, 1);
			`CHK("evt_int", 1'b0, int_n)
			stat(8'h07, m, d);
			`CHK("evt_flag", m, d & m)
			`CHK("evt_hold", prv & ~m, d & ~m)
			`CHK("evt_rel", 1'b1, int_n)
		end
		wr(8'h17, 8'h6f);
		p = '0;
		p.rx_mf = 1'b1;
		u_e1s_line_model.pulse(p, 1);
		`CHK("evt_masked", 1'b1, int_n)
		stat(8'h07, 8'h80, d);
		`CHK("evt_masked_flag", 8'h80, d & 8'h80)
		// Free-running receive CRC multiframe flag with CRC-4 off
		cfg = e1s_cfg_t'(5'h12);
		wr(8'h17, 8'h02);
		stat(8'h07, 8'h02, d);
		wait_int(100, k);
		`CHK("rx_crc_multiframe_flag_free", 1'b0, int_n)
		stat(8'h07, 8'h02, d);
		cfg = e1s_cfg_t'(5'h13);
		wr(8'h17, 8'h04);
		stat(8'h07, 8'h04, d);
		u_e1s_line_model.tx_run = 1'b0;
		wait_int(300, k);
		`CHK("tx_clock_loss_flag_int", 1'b0, int_n)
		`CHK("tx_clock_loss_flag_time", 1'b1, k > 66)
		`CHK("tx_clock_loss_flag_pin", 1'b1, tx_clock_loss_flag_pin)
		cfg = e1s_cfg_t'(5'h11);
		repeat (3) @(negedge clk);
		`CHK("tx_clock_loss_flag_pin_dis", 1'b0, tx_clock_loss_flag_pin)
		cfg = e1s_cfg_t'(5'h13);
		repeat (3) @(negedge clk);
		`CHK("tx_clock_loss_flag_pin_back", 1'b1, tx_clock_loss_flag_pin)
		u_e1s_line_model.tx_run = 1'b1;
		repeat (20) @(negedge clk);
		`CHK("tx_clock_loss_flag_off", 1'b0, tx_clock_loss_flag_pin)
		stat(8'h07, 8'h04, d);
		wr(8'h17, 8'h00);
		wr(8'h16, 8'h01);
		alarm = 8'h02;
		repeat (8) @(negedge clk);
		`CHK("alm_masked", 1'b1, int_n)
		alarm = 8'h03;
		repeat (8) @(negedge clk);
		`CHK("alm_int", 1'b0, int_n)
		stat(8'h06, 8'h01, d);
		`CHK("alm_flag", 8'h01, d)
		`CHK("alm_rel", 1'b1, int_n)
		alarm = 8'h02;
		repeat (8) @(negedge clk);
		`CHK("alm_fall", 1'b0, int_n)
		stat(8'h06, 8'h03, d);
		wr(8'h16, 8'h00);
		wait_sec(k);
		wait_sec(k);
		`CHK("sec_fast", 1'b1, k > 960 && k < 1030)
		// Pulse masks: 4d0 all four error inputs, 500 bpv and cv, 0c0 crc and E-bit
		row(5'h13, 19'h00000, 19'h004d0, 5, '{16'h5, 10'h5, 10'h5, 12'h5});
		row(5'h13, 19'h0000c, 19'h004d0, 3, '{16'h3, 10'h0, 10'h0, 12'h0});
		row(5'h13, 19'h00001, 19'h004d0, 2, '{16'h2, 10'h2, 10'h2, 12'h0});
		row(5'h17, 19'h00200, 19'h00500, 4, '{16'h0, 10'h0, 10'h0, 12'h0});
		row(5'h1b, 19'h00000, 19'h00500, 3, '{16'h3, 10'h0, 10'h0, 12'h0});
		row(5'h03, 19'h00000, 19'h000c0, 1030, '{16'h0, 10'h3ff, 10'h3ff, 12'h0});
		results();
	end

endmodule : tb

`default_nettype wire
